// ---- rtl/dsd_regs.svh ----
`ifndef DSD_REGS_SVH
`define DSD_REGS_SVH

// register byte offsets
`define DSD_CTRL_OFS        8'h00
`define DSD_STATUS_OFS      8'h04
`define DSD_STEPS_OFS       8'h08

// control register fields
`define DSD_CTRL_RUN_BIT    0
`define DSD_CTRL_HOLD_BIT   1
`define DSD_CTRL_RST        2'h1

// status register fields
`define DSD_ST_STATE_LSB    0
`define DSD_ST_PHASE_LSB    2
`define DSD_ST_PINS_LSB     4

// pin vector positions
`define DSD_PIN_CLK         0
`define DSD_PIN_EN_N        1
`define DSD_PIN_MODE        2
`define DSD_PIN_DIR         3
`define DSD_PIN_RST         4'h2

// step counter reset value
`define DSD_STEPS_RST       32'h0000_0000

`endif

// ---- rtl/dsd_pkg.sv ----
package dsd_pkg;

  // drive state
  typedef enum logic [1:0] {
    DSD_STOP  = 2'b00,
    DSD_ACCEL = 2'b01,
    DSD_CONST = 2'b10
  } dsd_state_e;

  typedef logic [1:0] dsd_phase_t;

endpackage : dsd_pkg

// ---- rtl/dsd_pin_if.sv ----
`timescale 1ns/1ps
interface dsd_pin_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;

  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface : dsd_pin_if

// ---- rtl/dsd_pin_sync.sv ----
`timescale 1ns/1ps
module dsd_pin_sync #(
  parameter int               WIDTH = 4,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pins in, stable levels out
  dsd_pin_if.sync   pins
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] rise_ff;

  ////////////////////////////////////////////////////////////////
  // three-stage synchroniser chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
    end
    else
    begin
      s1_ff <= pins.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_ff <= RST;
      rise_ff  <= '0;
    end
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_ff[i] == s3_ff[i])
        begin
          level_ff[i] <= s3_ff[i];
          rise_ff[i]  <= s3_ff[i] & ~level_ff[i];
        end
        else
        begin
          rise_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign pins.level = level_ff;
  assign pins.rise  = rise_ff;

endmodule : dsd_pin_sync

// ---- rtl/dsd_drive.sv ----
`timescale 1ns/1ps
`include "dsd_regs.svh"

////////////////////////////////////////////////////////////////
// Summary of operation
// - four phase outputs, A, B and complements, advanced on reference clock rising edges
// - pulses only while enable is low; enable high stops the motor
// - one step per reference clock rising edge, so speed follows its frequency
// - direction low steps forward, direction high steps backward
// - enable low, mode low: accelerate/decelerate drive in either direction
// - enable low, mode high: constant-speed drive in either direction
module dsd_drive (
  // clock and reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // apb slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // controller pins
  input  wire  logic        step_ref_clock,
  input  wire  logic        drive_enable_n,
  input  wire  logic        speed_mode_sel,
  input  wire  logic        rotation_dir_sel,
  // motor phase outputs
  output logic              phase_a_out,
  output logic              phase_b_out,
  output logic              phase_a_bar_out,
  output logic              phase_b_bar_out,
  // drive current boost while ramping
  output logic              current_boost
);

  ////////////////////////////////////////////////////////////////
  // declarations
  dsd_pin_if #(.WIDTH(4)) pin_bus ();

  logic [1:0]          ctrl_ff;
  logic [31:0]         steps_ff;
  logic [31:0]         nxt_steps;
  dsd_pkg::dsd_phase_t phase_ff;
  dsd_pkg::dsd_phase_t nxt_phase;
  dsd_pkg::dsd_state_e state_ff;
  dsd_pkg::dsd_state_e nxt_state;
  logic                run;
  logic                step;
  logic                drive_on;
  logic                a_lvl;
  logic                b_lvl;
  logic                pha_ff;
  logic                phb_ff;
  logic                phab_ff;
  logic                phbb_ff;
  logic                boost_ff;
  logic                pready_ff;
  logic [31:0]         prdata_ff;
  logic                pslverr_ff;
  logic                setup;
  logic                wr_en;
  logic                hit;
  logic [31:0]         rd_val;
  logic [31:0]         status_val;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pin_bus.raw[`DSD_PIN_CLK]  = step_ref_clock;
  assign pin_bus.raw[`DSD_PIN_EN_N] = drive_enable_n;
  assign pin_bus.raw[`DSD_PIN_MODE] = speed_mode_sel;
  assign pin_bus.raw[`DSD_PIN_DIR]  = rotation_dir_sel;

  dsd_pin_sync #(
    .WIDTH (4),
    .RST   (`DSD_PIN_RST)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (pin_bus.sync)
  );

  ////////////////////////////////////////////////////////////////
  // drive qualification
  // motor runs only with enable pin low and software run bit set
  assign run  = ~pin_bus.level[`DSD_PIN_EN_N] & ctrl_ff[`DSD_CTRL_RUN_BIT];
  // one step per reference clock rising edge
  assign step = run & pin_bus.rise[`DSD_PIN_CLK];

  // drive state from enable and speed mode
  always_comb
  begin
    if (!run)
    begin
      nxt_state = dsd_pkg::DSD_STOP;
    end
    else if (pin_bus.level[`DSD_PIN_MODE])
    begin
      nxt_state = dsd_pkg::DSD_CONST;
    end
    else
    begin
      nxt_state = dsd_pkg::DSD_ACCEL;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= dsd_pkg::DSD_STOP;
    end
    else
    begin
      case (state_ff)
        dsd_pkg::DSD_STOP:  state_ff <= nxt_state;
        dsd_pkg::DSD_ACCEL: state_ff <= nxt_state;
        dsd_pkg::DSD_CONST: state_ff <= nxt_state;
        default:            state_ff <= dsd_pkg::DSD_STOP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // phase sequencer
  // forward counts up, reverse counts down
  always_comb
  begin
    nxt_phase = phase_ff;
    if (step)
    begin
      if (pin_bus.level[`DSD_PIN_DIR])
      begin
        nxt_phase = phase_ff - 2'd1;
      end
      else
      begin
        nxt_phase = phase_ff + 2'd1;
      end
    end
  end

  // phase index holds position while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_ff <= 2'b00;
    end
    else
    begin
      phase_ff <= nxt_phase;
    end
  end

  // two-phase-on pattern: 10, 11, 01, 00
  assign a_lvl    = ~phase_ff[1];
  assign b_lvl    = phase_ff[1] ^ phase_ff[0];
  // hold bit keeps windings energized while stopped
  assign drive_on = run | ctrl_ff[`DSD_CTRL_HOLD_BIT];

  // registered phase outputs, all low when de-energized
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pha_ff  <= 1'b0;
      phb_ff  <= 1'b0;
      phab_ff <= 1'b0;
      phbb_ff <= 1'b0;
    end
    else
    begin
      pha_ff  <= drive_on & a_lvl;
      phb_ff  <= drive_on & b_lvl;
      phab_ff <= drive_on & ~a_lvl;
      phbb_ff <= drive_on & ~b_lvl;
    end
  end

  // current boost during accel/decel drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boost_ff <= 1'b0;
    end
    else
    begin
      boost_ff <= (nxt_state == dsd_pkg::DSD_ACCEL);
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb access
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_ff & pwrite;

  // status word
  always_comb
  begin
    status_val = 32'h0000_0000;
    status_val[`DSD_ST_STATE_LSB +: 2] = state_ff;
    status_val[`DSD_ST_PHASE_LSB +: 2] = phase_ff;
    status_val[`DSD_ST_PINS_LSB +: 4]  = pin_bus.level;
  end

  // address decode
  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == `DSD_CTRL_OFS)
    begin
      rd_val = {30'h0000_0000, ctrl_ff};
    end
    else if (paddr == `DSD_STATUS_OFS)
    begin
      rd_val = status_val;
    end
    else if (paddr == `DSD_STEPS_OFS)
    begin
      rd_val = steps_ff;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // answer one cycle after setup: single-cycle access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit;
      if (setup && !pwrite)
      begin
        prdata_ff <= rd_val;
      end
      else if (!setup)
      begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= `DSD_CTRL_RST;
    end
    else if (wr_en && paddr == `DSD_CTRL_OFS)
    begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  // step counter, write clears, a step in the same cycle counts on from zero
  always_comb
  begin
    nxt_steps = steps_ff;
    if (wr_en && paddr == `DSD_STEPS_OFS)
    begin
      nxt_steps = `DSD_STEPS_RST;
    end
    if (step)
    begin
      nxt_steps = nxt_steps + 32'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      steps_ff <= `DSD_STEPS_RST;
    end
    else
    begin
      steps_ff <= nxt_steps;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign pready          = pready_ff;
  assign prdata          = prdata_ff;
  assign pslverr         = pslverr_ff;
  assign phase_a_out     = pha_ff;
  assign phase_b_out     = phb_ff;
  assign phase_a_bar_out = phab_ff;
  assign phase_b_bar_out = phbb_ff;
  assign current_boost   = boost_ff;

endmodule : dsd_drive

// ---- tb/dsd_drive_asserts.sv ----
`timescale 1ns/1ps
module dsd_drive_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller pins
  input wire logic drive_enable_n,
  input wire logic speed_mode_sel,
  input wire logic rotation_dir_sel,
  // motor side
  input wire logic phase_a_out,
  input wire logic phase_b_out,
  input wire logic phase_a_bar_out,
  input wire logic phase_b_bar_out,
  input wire logic current_boost
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any winding energised
  wire drv = phase_a_out | phase_a_bar_out | phase_b_out | phase_b_bar_out;
  ////////////////////////////////////////
  // one step seen at the pins while driving
  sequence s_step;
    drv && $past(drv) && $changed({phase_a_out, phase_b_out});
  endsequence
  sequence s_accel;
    (!drive_enable_n && !speed_mode_sel) [*8];
  endsequence
  sequence s_const;
    (!drive_enable_n && speed_mode_sel) [*8];
  endsequence
  property p_comp;
    drv |-> phase_a_bar_out == !phase_a_out && phase_b_bar_out == !phase_b_out;
  endproperty
  property p_stop;
    drive_enable_n [*8] |=> !drv;
  endproperty
  property p_fwd;
    s_step ##0 !rotation_dir_sel |-> phase_a_out == !$past(phase_b_out) && phase_b_out == $past(phase_a_out);
  endproperty
  property p_rev;
    s_step ##0 rotation_dir_sel |-> phase_b_out == !$past(phase_a_out) && phase_a_out == $past(phase_b_out);
  endproperty
  property p_accel;
    s_accel |-> current_boost;
  endproperty
  property p_const;
    s_const |-> !current_boost;
  endproperty
  ////////////////////////////////////////
  a_comp: assert property (p_comp) else $error("phase pair not complementary");
  a_stop: assert property (p_stop) else $error("phases driven while disabled");
  a_fwd: assert property (p_fwd) else $error("forward step out of order");
  a_rev: assert property (p_rev) else $error("reverse step out of order");
  a_accel: assert property (p_accel) else $error("no boost in ramp mode");
  a_const: assert property (p_const) else $error("boost in constant mode");
endmodule : dsd_drive_asserts

// ---- tb/dsd_ctl_model.sv ----
`timescale 1ns/1ps
module dsd_ctl_model #(
  parameter logic [3:0] START = 4'h8,
  parameter logic [3:0] TGT   = 4'h3
) (
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // commands from the bench
  input  wire logic   run,
  input  wire logic   dir,
  // pins towards the drive
  output logic        step_ref_clock,
  output logic        drive_enable_n,
  output logic        speed_mode_sel,
  output logic        rotation_dir_sel,
  // reference rises issued
  output logic [31:0] rises
);
  logic [3:0] half_ff;
  logic [3:0] cnt_ff;
  assign rotation_dir_sel = dir;
  // ramped reference clock, still while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_ref_clock <= 1'h0;
      drive_enable_n <= 1'h1;
      speed_mode_sel <= 1'h0;
      half_ff        <= START;
      cnt_ff         <= 4'h0;
      rises          <= 32'h0;
    end
    else if (drive_enable_n)
    begin
      drive_enable_n <= !run;
      half_ff        <= START;
      cnt_ff         <= 4'h0;
      step_ref_clock <= 1'h0;
    end
    else if (cnt_ff != half_ff)
      cnt_ff <= cnt_ff + 4'h1;
    else
    begin
      cnt_ff         <= 4'h0;
      step_ref_clock <= !step_ref_clock;
      if (!step_ref_clock)
      begin
        rises          <= rises + 32'h1;
        speed_mode_sel <= run && half_ff == TGT;
        if (run && half_ff != TGT)
          half_ff <= half_ff - 4'h1;
        else if (!run && half_ff != START)
          half_ff <= half_ff + 4'h1;
      end
      else if (!run && half_ff == START)
        drive_enable_n <= 1'h1;
    end
  end
endmodule : dsd_ctl_model

// ---- tb/dsd_drive_tb.sv ----
`timescale 1ns/1ps
`include "dsd_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t got %h", $time, g); end end
module dsd_drive_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        run;
  logic        dir;
  logic        step_ref_clock;
  logic        drive_enable_n;
  logic        speed_mode_sel;
  logic        rotation_dir_sel;
  logic        phase_a_out;
  logic        phase_b_out;
  logic        phase_a_bar_out;
  logic        phase_b_bar_out;
  logic        current_boost;
  logic [31:0] rises;
  logic [31:0] rdat;
  logic        err;
  int          num_errors;
  int          n_checks;
  int          cyc;
  dsd_drive dut (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pready           (pready),
    .prdata           (prdata),
    .pslverr          (pslverr),
    .step_ref_clock   (step_ref_clock),
    .drive_enable_n   (drive_enable_n),
    .speed_mode_sel   (speed_mode_sel),
    .rotation_dir_sel (rotation_dir_sel),
    .phase_a_out      (phase_a_out),
    .phase_b_out      (phase_b_out),
    .phase_a_bar_out  (phase_a_bar_out),
    .phase_b_bar_out  (phase_b_bar_out),
    .current_boost    (current_boost)
  );
  dsd_ctl_model u_ctl (
    .pclk             (pclk),
    .presetn          (presetn),
    .run              (run),
    .dir              (dir),
    .step_ref_clock   (step_ref_clock),
    .drive_enable_n   (drive_enable_n),
    .speed_mode_sel   (speed_mode_sel),
    .rotation_dir_sel (rotation_dir_sel),
    .rises            (rises)
  );
  always #12.5 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  // one apb transfer, read data and error kept
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rdat    = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  // reset values and an unmapped word
  task automatic t_regs();
    apb(1'h0, `DSD_CTRL_OFS, 32'h0);
    `CHK(rdat, {30'h0, `DSD_CTRL_RST})
    apb(1'h0, `DSD_STEPS_OFS, 32'h0);
    `CHK(rdat, `DSD_STEPS_RST)
    apb(1'h1, 8'h0c, 32'hffff_ffff);
    `CHK(err, 1'h1)
    apb(1'h0, 8'h0c, 32'h0);
    `CHK({err, rdat}, 33'h1_0000_0000)
    apb(1'h0, `DSD_STATUS_OFS, 32'h0);
    `CHK(rdat[1:0], dsd_pkg::DSD_STOP)
    apb(1'h1, `DSD_STATUS_OFS, 32'hffff_ffff);
    `CHK(err, 1'h0)
    apb(1'h1, `DSD_CTRL_OFS, 32'h0);
    apb(1'h0, `DSD_CTRL_OFS, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'h1, `DSD_CTRL_OFS, 32'hffff_fffd);
    apb(1'h0, `DSD_CTRL_OFS, 32'h0);
    `CHK(rdat, {30'h0, `DSD_CTRL_RST})
  endtask : t_regs
  // ramp up, cruise, ramp down in one direction
  task automatic t_run(input logic d);
    dsd_pkg::dsd_phase_t i0;
    logic [31:0]         st;
    apb(1'h1, `DSD_STEPS_OFS, 32'h0);
    apb(1'h0, `DSD_STATUS_OFS, 32'h0);
    i0  = rdat[3:2];
    st  = rises;
    dir <= d;
    run <= 1'h1;
    repeat (12) @(posedge pclk);
    apb(1'h0, `DSD_STATUS_OFS, 32'h0);
    `CHK(rdat[1:0], dsd_pkg::DSD_ACCEL)
    `CHK(current_boost, 1'h1)
    do
      @(posedge pclk);
    while (speed_mode_sel !== 1'h1);
    repeat (40) @(posedge pclk);
    apb(1'h0, `DSD_STATUS_OFS, 32'h0);
    `CHK(rdat[1:0], dsd_pkg::DSD_CONST)
    `CHK(current_boost, 1'h0)
    run <= 1'h0;
    do
      @(posedge pclk);
    while (drive_enable_n !== 1'h1);
    repeat (10) @(posedge pclk);
    `CHK({phase_a_out, phase_b_out, phase_a_bar_out, phase_b_bar_out}, 4'h0)
    st = rises - st;
    apb(1'h0, `DSD_STEPS_OFS, 32'h0);
    `CHK(rdat, st)
    apb(1'h0, `DSD_STATUS_OFS, 32'h0);
    `CHK(rdat[3:2], d ? i0 - st[1:0] : i0 + st[1:0])
  endtask : t_run
  ////////////////////////////////////////
  initial
  begin
    pclk    = 1'h0;
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    run     = 1'h0;
    dir     = 1'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_run(1'h0);
    t_run(1'h1);
    close_out();
  end
endmodule : dsd_drive_tb
bind dsd_drive dsd_drive_asserts u_chk (
  .pclk             (pclk),
  .presetn          (presetn),
  .drive_enable_n   (drive_enable_n),
  .speed_mode_sel   (speed_mode_sel),
  .rotation_dir_sel (rotation_dir_sel),
  .phase_a_out      (phase_a_out),
  .phase_b_out      (phase_b_out),
  .phase_a_bar_out  (phase_a_bar_out),
  .phase_b_bar_out  (phase_b_bar_out),
  .current_boost    (current_boost)
);
